// ===== design/rps_map.svh
// Overview of operation
// (R1) Power-on reset is made inside the block; no pin timing needed at power-up.
// (R2) Outside party holds the low reset input at least 100 ms, then releases.
// (R3) External reset on battery alone shuts down every generated supply.
// (R4) After a battery reset, stay off until the power button, then boot.
// (R5) With auto-restart set beforehand, a battery reset reboots at once.
// (R6) On 5 V, external reset resets only digital sections; supplies keep running.
// (R7) On 5 V reset with switching regulator running, revert to linear regulators.
// (R8) Real-time counter and alarm advance on a shared once-per-second pulse.
// (R9) Watchdog and millisecond counter advance on a common once-per-millisecond tick.
// (R10) Real-time counter, alarm and persistent bits stay alive in crystal domain.
// (R11) External reset is synchronised and filtered; only a full-length hold counts.
`ifndef RPS_MAP_SVH
`define RPS_MAP_SVH

// ****************************************
// Timing
// ****************************************
`define RPS_CLK_MHZ       125
`define RPS_RST_MIN_MS    100
`define RPS_POR_CYCLES    16
`define RPS_CYC_PER_MS    (`RPS_CLK_MHZ * 1000)
`define RPS_MS_PER_S      1000
`define RPS_BOOT_CYCLES   64

`endif

// ===== design/rps_pkg.sv
package rps_pkg;

    typedef enum logic [4:0] {
        RPS_POR   = 5'b0_0001,
        RPS_BOOT  = 5'b0_0010,
        RPS_RUN   = 5'b0_0100,
        RPS_OFF   = 5'b0_1000,
        RPS_DRST  = 5'b1_0000
    } rps_state_t;

endpackage : rps_pkg

// ===== design/rps_tick_gen.sv
`timescale 1ns/1ps
`include "rps_map.svh"

module rps_tick_gen
#(
    parameter int CYC_PER_MS = `RPS_CYC_PER_MS,
    parameter int MS_PER_S   = `RPS_MS_PER_S
)
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // Ticks
    output logic      ms_tick,
    output logic      sec_tick
);

    logic [31:0] cyc_cnt;
    logic [31:0] ms_cnt;
    wire         cyc_wrap = (cyc_cnt == 32'(CYC_PER_MS - 1));
    wire         ms_wrap  = (ms_cnt == 32'(MS_PER_S - 1));

    // ****************************************
    // Dividers
    // ****************************************
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cyc_cnt  <= 32'h0000_0000;
            ms_cnt   <= 32'h0000_0000;
            ms_tick  <= 1'b0;
            sec_tick <= 1'b0;
        end
        else
        begin
            cyc_cnt  <= cyc_wrap ? 32'h0000_0000 : cyc_cnt + 32'h0000_0001;
            ms_tick  <= cyc_wrap; // see (R9)
            sec_tick <= cyc_wrap && ms_wrap; // see (R8)
            if (cyc_wrap)
                ms_cnt <= ms_wrap ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
        end
    end

endmodule : rps_tick_gen

// ===== design/rps_sequencer.sv
`timescale 1ns/1ps
`include "rps_map.svh"

module rps_sequencer
#(
    parameter int RST_MIN_CYCLES = `RPS_RST_MIN_MS * `RPS_CYC_PER_MS,
    parameter int CYC_PER_MS     = `RPS_CYC_PER_MS,
    parameter int MS_PER_S       = `RPS_MS_PER_S,
    parameter int BOOT_CYCLES    = `RPS_BOOT_CYCLES
)
(
    // Always-on crystal domain clock and its own reset
    input  wire logic mclk,
    input  wire logic rst,
    // Pins
    input  wire logic external_reset_input_n,
    input  wire logic power_button_input,
    // Supply status and settings
    input  wire logic supply_5v_present,
    input  wire logic auto_restart_en,
    input  wire logic switching_regulator_req,
    // Power control
    output logic      supplies_on,
    output logic      switching_regulator_on,
    output logic      linear_regulators_on,
    output logic      digital_reset,
    // Time domains
    output logic      ms_tick,
    output logic      sec_tick,
    output logic      seq_state_run
);

    import rps_pkg::*;

    // ****************************************
    // Internal power-on reset
    // ****************************************
    // Counts from an all-zero power-up value; no pin needed
    logic [7:0] por_cnt = 8'h00;
    logic       por_done;
    assign por_done = (por_cnt == 8'(`RPS_POR_CYCLES));

    always_ff @(posedge mclk)
    begin
        if (!por_done)
            por_cnt <= por_cnt + 8'h01; // see (R1)
    end

    wire        int_rst = rst || !por_done; // see (R1)

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [1:0] rstn_sync;
    logic [1:0] btn_sync;
    wire        rst_pin_low = !rstn_sync[1];
    wire        btn_pressed = btn_sync[1];

    always_ff @(posedge mclk)
    begin
        if (int_rst)
        begin
            rstn_sync <= 2'b11;
            btn_sync  <= 2'b00;
        end
        else
        begin
            rstn_sync <= {rstn_sync[0], external_reset_input_n}; // see (R11)
            btn_sync  <= {btn_sync[0], power_button_input};
        end
    end

    // ****************************************
    // Minimum-hold filter
    // ****************************************
    // A glitch shorter than the hold time restarts the count
    logic [31:0] hold_cnt;
    logic        held;
    logic        held_d;
    wire         hold_full = (hold_cnt == 32'(RST_MIN_CYCLES - 1));
    wire         ext_rst_ev = held && !held_d;

    always_ff @(posedge mclk)
    begin
        if (int_rst)
        begin
            hold_cnt <= 32'h0000_0000;
            held     <= 1'b0;
            held_d   <= 1'b0;
        end
        else
        begin
            held_d <= held;
            if (!rst_pin_low)
            begin
                hold_cnt <= 32'h0000_0000;
                held     <= 1'b0;
            end
            else if (hold_full)
                held <= 1'b1; // see (R2) (R11)
            else
                hold_cnt <= hold_cnt + 32'h0000_0001;
        end
    end

    // ****************************************
    // Auto-restart captured ahead of the reset
    // ****************************************
    logic auto_armed;

    always_ff @(posedge mclk)
    begin
        if (int_rst)
            auto_armed <= 1'b0;
        else if (!rst_pin_low)
            auto_armed <= auto_restart_en; // see (R5)
    end

    // ****************************************
    // Sequencer
    // ****************************************
    rps_state_t  state;
    rps_state_t  next_state;
    logic [7:0]  boot_cnt;
    wire         boot_done = (boot_cnt == 8'(BOOT_CYCLES - 1));

    always_comb
    begin
        next_state = state;
        unique case (state)
            RPS_POR:  next_state = RPS_BOOT;
            RPS_BOOT: if (boot_done) next_state = RPS_RUN;
            RPS_RUN:
            begin
                if (ext_rst_ev)
                    next_state = supply_5v_present ? RPS_DRST : RPS_OFF; // see (R3) (R6)
            end
            RPS_OFF:
            begin
                // Waits for pin release so a held reset does not reboot
                if (!rst_pin_low && (auto_armed || btn_pressed))
                    next_state = RPS_BOOT; // see (R4) (R5)
            end
            RPS_DRST: if (!rst_pin_low) next_state = RPS_BOOT; // see (R6)
            default:  next_state = RPS_POR;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (int_rst)
        begin
            state    <= RPS_POR;
            boot_cnt <= 8'h00;
        end
        else
        begin
            state    <= next_state;
            boot_cnt <= (state == RPS_BOOT) ? boot_cnt + 8'h01 : 8'h00;
        end
    end

    // ****************************************
    // Power outputs
    // ****************************************
    logic sw_reg;

    always_ff @(posedge mclk)
    begin
        if (int_rst)
        begin
            supplies_on   <= 1'b0;
            sw_reg        <= 1'b0;
            digital_reset <= 1'b1;
            seq_state_run <= 1'b0;
        end
        else
        begin
            supplies_on   <= (next_state != RPS_OFF) && (next_state != RPS_POR); // see (R3)
            // A 5 V reset drops back to the default linear path; a battery reset turns the linear regulators off too
            sw_reg        <= (next_state == RPS_RUN) && switching_regulator_req; // see (R7)
            digital_reset <= (next_state != RPS_RUN); // see (R6)
            seq_state_run <= (next_state == RPS_RUN);
        end
    end

    assign switching_regulator_on = sw_reg;
    assign linear_regulators_on   = supplies_on && !sw_reg; // see (R7)

    // ****************************************
    // Always-on time domains
    // ****************************************
    // Only the internal reset (power-on or the domain's own rst) clears these; external resets do not
    rps_tick_gen #(
        .CYC_PER_MS (CYC_PER_MS),
        .MS_PER_S   (MS_PER_S)
    ) u_ticks (
        .mclk     (mclk),
        .rst      (int_rst),
        .ms_tick  (ms_tick),
        .sec_tick (sec_tick)
    ); // see (R8) (R9) (R10)

endmodule : rps_sequencer

// ===== tb/rps_monitor.sv
`timescale 1ns/1ps
module rps_monitor
#(
    parameter int CYC_PER_MS = 10,
    parameter int MS_PER_S   = 4
)
(
    // Clock, reset, inputs
    input wire logic mclk,
    input wire logic rst,
    input wire logic external_reset_input_n,
    input wire logic supply_5v_present,
    // Outputs
    input wire logic supplies_on,
    input wire logic switching_regulator_on,
    input wire logic linear_regulators_on,
    input wire logic digital_reset,
    input wire logic ms_tick,
    input wire logic sec_tick,
    input wire logic seq_state_run
);
    localparam int SEC = CYC_PER_MS * MS_PER_S;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    property p_lin;
        linear_regulators_on == (supplies_on && !switching_regulator_on);
    endproperty
    a_lin: assert property (p_lin) else $error("linear enable wrong");
    property p_sms;
        sec_tick |-> ms_tick;
    endproperty
    a_sms: assert property (p_sms) else $error("second off ms grid");
    property p_gap;
        ms_tick |=> !ms_tick [*8];
    endproperty
    a_gap: assert property (p_gap) else $error("ms tick early");
    property p_ms;
        ms_tick |-> ##CYC_PER_MS ms_tick;
    endproperty
    a_ms: assert property (p_ms) else $error("ms period wrong");
    property p_sec;
        sec_tick |-> ##SEC sec_tick;
    endproperty
    a_sec: assert property (p_sec) else $error("second period wrong");
    property p_run;
        seq_state_run |-> !digital_reset && supplies_on;
    endproperty
    a_run: assert property (p_run) else $error("run state wrong");
    property p_keep;
        supply_5v_present && seq_state_run ##1 !seq_state_run |-> supplies_on;
    endproperty
    a_keep: assert property (p_keep) else $error("5v reset cut supply");
    property p_filt;
        $fell(seq_state_run) |-> $past(!external_reset_input_n, 20);
    endproperty
    a_filt: assert property (p_filt) else $error("reset not filtered");
    c_sec: cover property (sec_tick);
    c_5v: cover property ($fell(seq_state_run) && supply_5v_present);
    c_up: cover property ($rose(seq_state_run));
endmodule : rps_monitor
bind rps_sequencer rps_monitor #(.CYC_PER_MS(CYC_PER_MS), .MS_PER_S(MS_PER_S)) u_mon
    (.mclk(mclk), .rst(rst), .external_reset_input_n(external_reset_input_n),
     .supply_5v_present(supply_5v_present), .supplies_on(supplies_on),
     .switching_regulator_on(switching_regulator_on), .ms_tick(ms_tick),
     .linear_regulators_on(linear_regulators_on), .digital_reset(digital_reset),
     .sec_tick(sec_tick), .seq_state_run(seq_state_run));

// ===== tb/rps_pin_model.sv
`timescale 1ns/1ps
module rps_pin_model
(
    // Commands
    input  wire logic mclk,
    input  wire logic rst_go,
    input  wire logic btn_go,
    input  wire logic [31:0] low_len,
    // Pins
    output logic      external_reset_input_n,
    output logic      power_button_input
);
    int cnt = 0;
    int bcnt = 0;
    // Low for the commanded span, then released
    assign external_reset_input_n = (cnt == 0);
    assign power_button_input = (bcnt != 0);
    always @(posedge mclk)
    begin
        cnt <= rst_go ? low_len : (cnt != 0 ? cnt - 1 : 0);
        bcnt <= btn_go ? 4 : (bcnt != 0 ? bcnt - 1 : 0);
    end
endmodule : rps_pin_model

// ===== tb/rps_sequencer_test.sv
`timescale 1ns/1ps
module rps_sequencer_test;
    logic mclk, rst, supply_5v_present, auto_restart_en, switching_regulator_req;
    logic rst_go, btn_go;
    int   low_len, n_mismatch, checks, n_ms, n_s;
    wire logic external_reset_input_n, power_button_input, supplies_on, digital_reset;
    wire logic switching_regulator_on, linear_regulators_on, ms_tick, sec_tick, seq_state_run;
    rps_pin_model pins (.mclk(mclk), .rst_go(rst_go), .btn_go(btn_go), .low_len(low_len),
        .external_reset_input_n(external_reset_input_n), .power_button_input(power_button_input));
    // Short counts keep the run brief
    rps_sequencer #(.RST_MIN_CYCLES(20), .CYC_PER_MS(10), .MS_PER_S(4)) dut (.mclk(mclk),
        .rst(rst), .external_reset_input_n(external_reset_input_n),
        .power_button_input(power_button_input), .supply_5v_present(supply_5v_present),
        .auto_restart_en(auto_restart_en), .switching_regulator_req(switching_regulator_req),
        .supplies_on(supplies_on), .switching_regulator_on(switching_regulator_on),
        .linear_regulators_on(linear_regulators_on), .digital_reset(digital_reset),
        .ms_tick(ms_tick), .sec_tick(sec_tick), .seq_state_run(seq_state_run));
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task chk(input string nm, input logic e, input logic g);
        checks++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
            n_mismatch++;
        end
    endtask : chk
    task go(input int len);
        @(posedge mclk);
        low_len <= len;
        rst_go <= 1'b1;
        @(posedge mclk);
        rst_go <= 1'b0;
    endtask : go
    task wait_run(input logic v);
        for (int i = 0; i < 300 && seq_state_run !== v; i++) @(negedge mclk);
        chk("run", v, seq_state_run);
    endtask : wait_run
    task stop_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    initial
    begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        stop_test();
    end
    task t_boot;
        wait_run(1'b1);
        chk("supply", 1'b1, supplies_on);
        chk("sw_on", 1'b1, switching_regulator_on);
        chk("lin_off", 1'b0, linear_regulators_on);
    endtask : t_boot
    task t_short;
        go(10);
        repeat (40) @(negedge mclk);
        chk("short", 1'b1, seq_state_run);
    endtask : t_short
    task t_5v;
        go(25);
        wait_run(1'b0);
        @(negedge mclk);
        chk("5v_sup", 1'b1, supplies_on);
        chk("5v_drst", 1'b1, digital_reset);
        chk("5v_lin", 1'b1, linear_regulators_on);
        wait_run(1'b1);
    endtask : t_5v
    task t_bat;
        @(posedge mclk);
        supply_5v_present <= 1'b0;
        go(25);
        wait_run(1'b0);
        repeat (2) @(negedge mclk);
        chk("bat_sup", 1'b0, supplies_on);
        chk("bat_lin", 1'b0, linear_regulators_on);
        repeat (100) @(negedge mclk);
        chk("bat_off", 1'b0, seq_state_run);
        @(posedge mclk);
        btn_go <= 1'b1;
        @(posedge mclk);
        btn_go <= 1'b0;
        wait_run(1'b1);
    endtask : t_bat
    task t_auto;
        @(posedge mclk);
        auto_restart_en <= 1'b1;
        go(25);
        wait_run(1'b0);
        wait_run(1'b1);
    endtask : t_auto
    task t_ticks;
        {n_ms, n_s} = 0;
        repeat (400)
        begin
            @(negedge mclk);
            n_ms += ms_tick;
            n_s += sec_tick;
        end
        chk("ms", 1'b1, n_ms == 40);
        chk("sec", 1'b1, n_s == 10);
    endtask : t_ticks
    initial
    begin
        {rst, supply_5v_present, switching_regulator_req} = 3'b111;
        {auto_restart_en, rst_go, btn_go, low_len} = 0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        t_boot();
        t_short();
        t_5v();
        t_bat();
        t_auto();
        t_ticks();
        stop_test();
    end
endmodule : rps_sequencer_test
